// file: rtl/lbp_int_decode.sv
// lbp_int_decode: turns one synchronised peripheral interrupt level into an active-high request
// assumes pin_s is already synchronised to ref_clk
`timescale 1ns/1ps
module lbp_int_decode (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_s,
  input wire logic active_low,
  input wire logic enable,
  output logic req
);

  // a disabled input never raises a request, whatever the pin does
  wire logic next_req = enable & (pin_s ^ active_low);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req <= 1'b0;
    end else begin
      req <= next_req;
    end
  end

endmodule // lbp_int_decode

// file: rtl/lbp_local_bus_cfg.sv
// lbp_local_bus_cfg: local bus side config of dma request routing and peripheral interrupt decode
// assumes an avalon-mm master on ref_clk and asynchronous peripheral pins
// Operation
// - shared mode, direction 0: channel a request is a receive request
// - shared mode, direction 1: channel a request is a transmit request
// - direction select acts only while shared channel a mode is set
// - first decode select 0: first peripheral decoding, input one active high
// - first decode select 1: second peripheral decoding, input one active low
// - second decode select 0: first peripheral decoding, input two active high
// - second decode select 1: second peripheral decoding, input two active low
// - separate pins 0: input one serves both channels, input two disabled
// - separate pins 1: input one for channel a, input two for channel b
// - shared mode carries both requests and acknowledges on channel a lines
// - reset default is separate transmit and receive dma signals
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "lbp_regs_cfg.svh"
module lbp_local_bus_cfg (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic chan_a_request_line,
  input wire logic chan_b_request_line,
  output logic chan_a_ack_line,
  output logic chan_b_ack_line,
  input wire logic periph_int_in_one,
  input wire logic periph_int_in_two,
  output logic dma_tx_req,
  output logic dma_rx_req,
  input wire logic dma_tx_ack,
  input wire logic dma_rx_ack,
  output logic chan_a_int_req,
  output logic chan_b_int_req,
  output logic int_one_decode_type,
  output logic int_two_decode_type,
  output logic irq
);

  lbp_pkg::lbp_req_t req;
  lbp_pkg::lbp_cfg_t cfg;
  lbp_pkg::lbp_evt_t status;
  lbp_pkg::lbp_evt_t mask;
  logic [`LBP_NUM_PINS-1:0] pin_s;
  logic [`LBP_NUM_INT-1:0] int_lvl;
  logic [`LBP_NUM_INT-1:0] int_pol;
  logic [`LBP_NUM_INT-1:0] int_en;
  logic drq_prev;
  logic int_a_prev;
  logic int_b_prev;

  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.address = avs_address;
  assign req.byteenable = avs_byteenable;
  assign req.writedata = avs_writedata;

  // pin order: request a, request b, interrupt one, interrupt two
  lbp_sync #(
    .W(`LBP_NUM_PINS)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({periph_int_in_two, periph_int_in_one, chan_b_request_line, chan_a_request_line}),
    .q(pin_s)
  );

  wire logic req_a_s = pin_s[0];
  wire logic req_b_s = pin_s[1];
  wire logic [`LBP_NUM_INT-1:0] int_pin_s = pin_s[3:2];

  // bus decode
  wire logic sel_config = req.address == `LBP_OFS_CONFIG;
  wire logic sel_status = req.address == `LBP_OFS_STATUS;
  wire logic sel_mask = req.address == `LBP_OFS_MASK;
  wire logic sel_state = req.address == `LBP_OFS_STATE;
  // a write takes effect only on the edge where waitrequest is seen low
  wire logic wr_go = req.write & ~avs_waitrequest & req.byteenable[0];
  wire logic rd_load = req.read & avs_waitrequest;
  wire logic next_waitrequest = ~((req.read | req.write) & avs_waitrequest);

  wire lbp_pkg::lbp_cfg_t next_cfg = (wr_go & sel_config) ?
    lbp_pkg::lbp_cfg_t'(req.writedata[4:0]) : cfg;
  wire lbp_pkg::lbp_evt_t next_mask = (wr_go & sel_mask) ?
    lbp_pkg::lbp_evt_t'(req.writedata[2:0]) : mask;

  // dma request routing
  wire logic shared = cfg.shared_chan_a;
  wire logic shared_tx = shared & cfg.dma_direction_select;
  wire logic shared_rx = shared & ~cfg.dma_direction_select;
  // in separate mode the direction select has no effect at all
  wire logic next_tx_req = shared ? (shared_tx & req_a_s) : req_a_s;
  wire logic next_rx_req = shared ? (shared_rx & req_a_s) : req_b_s;
  // shared mode: only the acknowledge picked by direction select leaves on channel a, channel b stays idle
  wire logic next_ack_a = shared ? (cfg.dma_direction_select ? dma_tx_ack : dma_rx_ack)
    : dma_tx_ack;
  wire logic next_ack_b = ~shared & dma_rx_ack;

  // interrupt decode: second peripheral type is active low
  assign int_pol[0] = cfg.first_int_decode_select;
  assign int_pol[1] = cfg.second_int_decode_select;
  assign int_en[0] = 1'b1;
  assign int_en[1] = cfg.separate_int_pins;

  genvar gi;
  generate
    for (gi = 0; gi < `LBP_NUM_INT; gi++) begin : g_int
      lbp_int_decode u_dec (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_s(int_pin_s[gi]),
        .active_low(int_pol[gi]),
        .enable(int_en[gi]),
        .req(int_lvl[gi])
      );
    end
  endgenerate

  wire logic next_int_a = int_lvl[0];
  wire logic next_int_b = cfg.separate_int_pins ? int_lvl[1] : int_lvl[0];

  // events: rising edges of the routed requests
  wire logic drq_any = next_tx_req | next_rx_req;
  wire lbp_pkg::lbp_evt_t evt_set = '{
    drq: drq_any & ~drq_prev,
    int_b: next_int_b & ~int_b_prev,
    int_a: next_int_a & ~int_a_prev
  };
  wire lbp_pkg::lbp_evt_t evt_clr = (wr_go & sel_status) ?
    lbp_pkg::lbp_evt_t'(req.writedata[2:0]) : '0;
  // a set in the clearing cycle survives
  wire lbp_pkg::lbp_evt_t next_status = (status & ~evt_clr) | evt_set;
  // next mask as well as next status, so irq lines up with the unmasked status word
  wire logic next_irq = |(next_status & next_mask);

  wire logic [31:0] state_word = {24'h000000, int_lvl, pin_s, dma_tx_req, dma_rx_req};
  wire logic [31:0] next_readdata =
    sel_config ? {27'h0000000, cfg} :
    sel_status ? {29'h00000000, status} :
    sel_mask ? {29'h00000000, mask} :
    sel_state ? state_word : 32'h00000000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      if (rd_load) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg <= lbp_pkg::lbp_cfg_t'(`LBP_CFG_RESET);
      mask <= lbp_pkg::lbp_evt_t'(`LBP_MASK_RESET);
      status <= lbp_pkg::lbp_evt_t'(`LBP_EVT_RESET);
      irq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      mask <= next_mask;
      status <= next_status;
      irq <= next_irq;
    end
  end

  // dma side outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
      chan_a_ack_line <= 1'b0;
      chan_b_ack_line <= 1'b0;
      drq_prev <= 1'b0;
    end else begin
      dma_tx_req <= next_tx_req;
      dma_rx_req <= next_rx_req;
      chan_a_ack_line <= next_ack_a;
      chan_b_ack_line <= next_ack_b;
      drq_prev <= drq_any;
    end
  end

  // interrupt side outputs; the prev flops follow the routed levels, not the pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_a_int_req <= 1'b0;
      chan_b_int_req <= 1'b0;
      int_a_prev <= 1'b0;
      int_b_prev <= 1'b0;
    end else begin
      chan_a_int_req <= next_int_a;
      chan_b_int_req <= next_int_b;
      int_a_prev <= next_int_a;
      int_b_prev <= next_int_b;
    end
  end

  // decode type tells the peripheral access engine which register layout to use
  assign int_one_decode_type = cfg.first_int_decode_select;
  assign int_two_decode_type = cfg.second_int_decode_select;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_shared_rx_dir: assert property (
    cfg.shared_chan_a && !cfg.dma_direction_select && req_a_s
      |=> dma_rx_req && !dma_tx_req)
    else $error("shared request with direction 0 not routed to receive");

  a_shared_tx_dir: assert property (
    cfg.shared_chan_a && cfg.dma_direction_select && req_a_s
      |=> dma_tx_req && !dma_rx_req)
    else $error("shared request with direction 1 not routed to transmit");

  a_dir_ignored: assert property (
    !cfg.shared_chan_a
      |=> dma_tx_req == $past(req_a_s) && dma_rx_req == $past(req_b_s))
    else $error("direction select affected separate mode routing");

  a_int_one_high: assert property (
    !cfg.first_int_decode_select ##0 $stable(int_pin_s[0])
      |=> int_lvl[0] == $past(int_pin_s[0]))
    else $error("input one not decoded active high");

  a_int_one_low: assert property (
    cfg.first_int_decode_select && !int_pin_s[0] |=> int_lvl[0])
    else $error("input one low not seen as request in active low mode");

  a_int_two_high: assert property (
    cfg.separate_int_pins && !cfg.second_int_decode_select && int_pin_s[1]
      |=> int_lvl[1] ##1 (chan_b_int_req || !$past(cfg.separate_int_pins)))
    else $error("input two not decoded active high");

  a_int_two_low: assert property (
    cfg.separate_int_pins && cfg.second_int_decode_select && int_pin_s[1]
      |=> !int_lvl[1])
    else $error("input two high seen as request in active low mode");

  a_shared_int_pin: assert property (
    !cfg.separate_int_pins |=> chan_b_int_req == chan_a_int_req && !int_lvl[1])
    else $error("input two not disabled or channels not sharing input one");

  a_separate_int_pin: assert property (
    cfg.separate_int_pins |=> chan_b_int_req == $past(int_lvl[1]))
    else $error("channel b interrupt not taken from input two");

  a_shared_ack_line: assert property (
    cfg.shared_chan_a |=> !chan_b_ack_line
      && chan_a_ack_line == ($past(cfg.dma_direction_select) ? $past(dma_tx_ack)
      : $past(dma_rx_ack)))
    else $error("shared acknowledge not carried on channel a line");

  a_reset_separate: assert property (
    $past(rst) |-> !cfg.shared_chan_a)
    else $error("shared channel a mode set out of reset");

  a_status_sticky: assert property (
    status.int_a && !(wr_go && sel_status && req.writedata[0]) |=> status.int_a)
    else $error("status bit lost without a clearing write");

  a_irq_follows: assert property (
    irq == |(status & mask))
    else $error("interrupt output disagrees with unmasked status");

  a_wait_one: assert property (
    (req.read || req.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

  a_sep_ack_lines: assert property (
    !cfg.shared_chan_a
      |=> chan_a_ack_line == $past(dma_tx_ack) && chan_b_ack_line == $past(dma_rx_ack))
    else $error("separate mode acknowledges not on their own lines");

  a_shared_b_ignored: assert property (
    cfg.shared_chan_a && !req_a_s
      |=> !dma_tx_req && !dma_rx_req)
    else $error("channel b request routed while channel a is shared");

  a_int_one_idle: assert property (
    cfg.first_int_decode_select && int_pin_s[0]
      |=> !int_lvl[0])
    else $error("input one idle high seen as request in active low mode");

  a_int_two_req: assert property (
    cfg.separate_int_pins && cfg.second_int_decode_select && !int_pin_s[1]
      |=> int_lvl[1])
    else $error("input two low not seen as request in active low mode");

  a_chan_a_int: assert property (
    1'b1
      |=> chan_a_int_req == $past(int_lvl[0]))
    else $error("channel a interrupt not taken from input one");

  a_set_int_a: assert property (
    evt_set.int_a
      |=> status.int_a)
    else $error("channel a interrupt rise not recorded");

  a_set_int_b: assert property (
    evt_set.int_b
      |=> status.int_b)
    else $error("channel b interrupt rise not recorded");

  a_set_drq: assert property (
    evt_set.drq
      |=> status.drq)
    else $error("dma request rise not recorded");

  a_status_w1c: assert property (
    wr_go && sel_status && req.writedata[2] && !evt_set.drq
      |=> !status.drq)
    else $error("status bit not cleared by writing one");

  a_mask_write: assert property (
    wr_go && sel_mask
      |=> mask.drq == $past(avs_writedata[2]))
    else $error("mask write did not land");

  a_cfg_kept: assert property (
    req.write && !req.byteenable[0]
      |=> $stable(cfg))
    else $error("config changed by a write without byte lane 0");

  a_read_config: assert property (
    req.read && avs_waitrequest && sel_config
      |=> avs_readdata == {27'h0000000, $past(cfg)})
    else $error("config read returned a wrong word");

  a_wait_idle: assert property (
    !req.read && !req.write
      |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");

  a_readdata_hold: assert property (
    !(req.read && avs_waitrequest)
      |=> $stable(avs_readdata))
    else $error("read data changed outside a read");

  c_shared_rx: cover property (cfg.shared_chan_a && !cfg.dma_direction_select && dma_rx_req);
  c_shared_tx: cover property (cfg.shared_chan_a && cfg.dma_direction_select && dma_tx_req);
  c_int_two_sep: cover property (cfg.separate_int_pins && chan_b_int_req && !chan_a_int_req);
  c_irq_raise: cover property (!irq ##1 irq);
  c_shared_ack: cover property (cfg.shared_chan_a && chan_a_ack_line);

endmodule // lbp_local_bus_cfg

// file: rtl/lbp_pkg.sv
// lbp_pkg: types shared by the local bus config block
// assumes the constants of lbp_regs_cfg.svh for field positions
package lbp_pkg;

  // field order follows the config word, bit 4 down to bit 0
  typedef struct packed {
    logic separate_int_pins;
    logic second_int_decode_select;
    logic first_int_decode_select;
    logic dma_direction_select;
    logic shared_chan_a;
  } lbp_cfg_t;

  typedef struct packed {
    logic drq;
    logic int_b;
    logic int_a;
  } lbp_evt_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } lbp_req_t;

endpackage

// file: rtl/lbp_regs_cfg.svh
// lbp_regs_cfg.svh: offsets, field positions and reset values of the local bus config block
// assumes byte addresses on a 32-bit avalon-mm slave, one aligned word per register
`ifndef LBP_REGS_CFG_SVH
`define LBP_REGS_CFG_SVH

`define LBP_OFS_CONFIG 4'h0
`define LBP_OFS_STATUS 4'h4
`define LBP_OFS_MASK 4'h8
`define LBP_OFS_STATE 4'hc

`define LBP_CFG_SHARED_BIT 0
`define LBP_CFG_DIR_SEL_BIT 1
`define LBP_CFG_DEC_ONE_BIT 2
`define LBP_CFG_DEC_TWO_BIT 3
`define LBP_CFG_SEP_INT_BIT 4
`define LBP_CFG_RESET 5'h00

`define LBP_EVT_INT_A_BIT 0
`define LBP_EVT_INT_B_BIT 1
`define LBP_EVT_DRQ_BIT 2
`define LBP_EVT_RESET 3'h0
`define LBP_MASK_RESET 3'h0

`define LBP_NUM_INT 2
`define LBP_NUM_PINS 4

`endif

// file: rtl/lbp_sync.sv
// lbp_sync: two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to ref_clk; only q is read outside
`timescale 1ns/1ps
module lbp_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // lbp_sync

// file: testbench/lbp_periph_model.sv
// lbp_periph_model: peripheral controllers on the local bus, seen at their pins
// assumes the bench commands which requests and interrupts are asserted
`timescale 1ns/1ps
module lbp_periph_model (
  input wire logic [3:0] act,
  input wire logic low_one,
  input wire logic low_two,
  output logic chan_a_request_line,
  output logic chan_b_request_line,
  output logic periph_int_in_one,
  output logic periph_int_in_two
);
  // act order {int two, int one, req b, req a}; requests are active high
  assign chan_a_request_line = act[0];
  assign chan_b_request_line = act[1];
  // an active-low peripheral idles its line high, so idle is never a request
  assign periph_int_in_one = act[2] ^ low_one;
  assign periph_int_in_two = act[3] ^ low_two;
endmodule // lbp_periph_model

// file: testbench/lbp_tb_top.sv
// local bus config testbench: table of routing and decode cases, then irq and bus cases
// assumes an avalon slave that may insert wait cycles; only the watchdog bounds a wait
`timescale 1ns/1ps
`include "lbp_regs_cfg.svh"
module local_bus_periph_int_dma_cfg_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [3:0] act = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, chan_a_request_line, chan_b_request_line;
  logic chan_a_ack_line, chan_b_ack_line, periph_int_in_one, periph_int_in_two;
  logic dma_tx_req, dma_rx_req, chan_a_int_req, chan_b_int_req;
  logic dma_tx_ack = 1'b0;
  logic dma_rx_ack = 1'b0;
  logic low_one = 1'b0;
  logic low_two = 1'b0;
  logic int_one_decode_type, int_two_decode_type, irq;
  // row: config, asserted {i2,i1,rb,ra}, acks {tx,rx}, {tx,rx,int a,int b,ack a,ack b}
  logic [16:0] rows [10];
  int fail_count = 0;
  int checks_done = 0;

  always #25 ref_clk = ~ref_clk;

  lbp_local_bus_cfg dut_u (.ref_clk, .rst, .avs_read, .avs_write, .avs_address,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .chan_a_request_line, .chan_b_request_line, .chan_a_ack_line, .chan_b_ack_line,
    .periph_int_in_one, .periph_int_in_two, .dma_tx_req, .dma_rx_req, .dma_tx_ack,
    .dma_rx_ack, .chan_a_int_req, .chan_b_int_req, .int_one_decode_type,
    .int_two_decode_type, .irq);

  lbp_periph_model pm_u (.act, .low_one, .low_two, .chan_a_request_line,
    .chan_b_request_line, .periph_int_in_one, .periph_int_in_two);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // one avalon transfer; w=0 reads; the bench timeout bounds the wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // an edge passes so a following call never reassigns the strobes in this step
    @(posedge ref_clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    rows[0] = {5'h00, 4'h1, 2'h2, 6'h22};
    rows[1] = {5'h00, 4'h6, 2'h1, 6'h1d};
    rows[2] = {5'h03, 4'h3, 2'h2, 6'h22};
    rows[3] = {5'h01, 4'h3, 2'h1, 6'h12};
    rows[4] = {5'h02, 4'h2, 2'h0, 6'h10};
    rows[5] = {5'h14, 4'h4, 2'h0, 6'h08};
    rows[6] = {5'h18, 4'h8, 2'h0, 6'h04};
    rows[7] = {5'h10, 4'h8, 2'h0, 6'h04};
    rows[8] = {5'h08, 4'h8, 2'h0, 6'h00};
    rows[9] = {5'h0c, 4'h0, 2'h0, 6'h00};
    repeat (11) @(posedge ref_clk);
    chk("reset outputs", 32'h1, {dma_tx_req, dma_rx_req, irq, avs_waitrequest});
    @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, `LBP_OFS_CONFIG, 32'h0, q);
    chk("config reset", 32'h0, q);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, `LBP_OFS_CONFIG, {27'h0, rows[i][16:12]}, q);
      low_one <= rows[i][14];
      low_two <= rows[i][15];
      act <= rows[i][11:8];
      {dma_tx_ack, dma_rx_ack} <= rows[i][7:6];
      repeat (6) @(posedge ref_clk);
      chk("routing", {24'h0, rows[i][5:0], rows[i][15:14]}, {24'h0, dma_tx_req, dma_rx_req,
        chan_a_int_req, chan_b_int_req, chan_a_ack_line, chan_b_ack_line,
        int_two_decode_type, int_one_decode_type});
      $display("row %0d done", i);
    end
    act <= 4'h0;
    low_one <= 1'b0;
    low_two <= 1'b0;
    {dma_tx_ack, dma_rx_ack} <= 2'h0;
    bus(1'b1, `LBP_OFS_CONFIG, 32'h0, q);
    repeat (6) @(posedge ref_clk);
    bus(1'b1, `LBP_OFS_STATUS, 32'h7, q);
    bus(1'b1, `LBP_OFS_MASK, 32'h4, q);
    act <= 4'h1;
    repeat (6) @(posedge ref_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, `LBP_OFS_STATUS, 32'h0, q);
    chk("status", 32'h4, q);
    bus(1'b1, `LBP_OFS_MASK, 32'h0, q);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `LBP_OFS_MASK, 32'h4, q);
    bus(1'b1, `LBP_OFS_STATUS, 32'h4, q);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 32'h0, q);
    avs_byteenable <= 4'h0;
    bus(1'b1, `LBP_OFS_CONFIG, 32'h1f, q);
    avs_byteenable <= 4'hf;
    bus(1'b0, `LBP_OFS_CONFIG, 32'h0, q);
    chk("config kept", 32'h0, q);
    $display("irq and bus tests done");
    bus(1'b1, `LBP_OFS_CONFIG, 32'h1f, q);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("midrun reset outputs", 32'h1, {dma_tx_req, dma_rx_req, irq, avs_waitrequest});
    rst <= 1'b0;
    bus(1'b0, `LBP_OFS_CONFIG, 32'h0, q);
    chk("config after reset", 32'h0, q);
    $display("midrun reset test done");
    final_report();
  end
endmodule // local_bus_periph_int_dma_cfg_tb_top
